// file: ctrl_link_assertions.sv
/*
 * Checker for the control link pair: decode relations and commit timing.
 * Assumes the bench wires in the link lines and the codec outputs.
 */
`timescale 1ns/1ps
module ctrl_link_assertions
	import ctrl_link_pkg::*;
(
	// Clock and reset
	input wire logic       sys_clk_in,
	input wire logic       rstn_in,
	// Link lines
	input wire logic       ctrl_phase_line,
	input wire logic       ctrl_clock_line,
	// Codec outputs
	input wire logic [1:0] clock_ratio_select_out,
	input wire logic [9:0] clock_ratio_out,
	input wire logic [5:0] volume_code_out,
	input wire logic [5:0] atten_db_out,
	input wire logic [3:0] bass_code_out,
	input wire logic [1:0] treble_code_out,
	input wire logic [4:0] bass_gain_db_out,
	input wire logic [2:0] treble_gain_db_out,
	input wire logic       tone_mode_high_out,
	input wire logic       tone_mode_low_out,
	input wire logic [1:0] converter_power_select_out,
	input wire logic       link_selected_out,
	input wire logic [1:0] link_group_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);

	// Cycles since the link clock rose; saturates so it never wraps
	typedef struct packed {
		logic [3:0] since;
		logic       clk_d;
	} chk_state_t;
	chk_state_t st_r;
	chk_state_t st_nxt;

	// Next state of the edge counter
	always_comb begin
		st_nxt = st_r;
		st_nxt.clk_d = ctrl_clock_line;
		if (ctrl_clock_line && !st_r.clk_d) begin
			st_nxt.since = 4'h0;
		end else if (st_r.since != 4'hF) begin
			st_nxt.since = st_r.since + 4'h1;
		end
	end

	// Register the counter; idle line is high
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_r <= '{4'hF, 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Eight cycles of data phase in a row
	sequence s_data_run;
		ctrl_phase_line [*8];
	endsequence

	property p_ratio;
		clock_ratio_out == (clock_ratio_select_out == 2'h0 ? 10'h200 :
			clock_ratio_select_out == 2'h1 ? 10'h180 :
			clock_ratio_select_out == 2'h2 ? 10'h100 : 10'h000);
	endproperty
	property p_atten;
		atten_db_out == (volume_code_out < 6'h02 ? 6'h00 :
			volume_code_out > 6'h3D ? 6'h3F : volume_code_out - 6'h01);
	endproperty
	property p_bass;
		bass_gain_db_out == (!(tone_mode_high_out || tone_mode_low_out) ? 5'h00 :
			({bass_code_out, 1'b0} > ((tone_mode_high_out && tone_mode_low_out) ? 5'h18 : 5'h12))
			? ((tone_mode_high_out && tone_mode_low_out) ? 5'h18 : 5'h12)
			: {bass_code_out, 1'b0});
	endproperty
	property p_treble;
		treble_gain_db_out == ((tone_mode_high_out || tone_mode_low_out) ?
			{treble_code_out, 1'b0} : 3'h0);
	endproperty
	property p_power;
		$changed(converter_power_select_out) |-> link_selected_out &&
			link_group_out == 2'h0 && st_r.since inside {[1:6]};
	endproperty
	property p_commit;
		$changed(volume_code_out) || $changed(clock_ratio_select_out) |->
			st_r.since inside {[1:6]};
	endproperty
	property p_data_grp;
		$changed(volume_code_out) |-> link_selected_out && link_group_out == 2'h0;
	endproperty
	property p_setup_grp;
		$changed(clock_ratio_select_out) |-> link_selected_out && link_group_out == 2'h2;
	endproperty
	property p_group_hold;
		s_data_run |-> $stable(link_group_out) && $stable(link_selected_out);
	endproperty

	a_ratio: assert property (p_ratio) else $error("clock ratio decode wrong");
	a_atten: assert property (p_atten) else $error("attenuation decode wrong");
	a_bass: assert property (p_bass) else $error("bass gain wrong");
	a_treble: assert property (p_treble) else $error("treble gain wrong");
	a_power: assert property (p_power) else $error("power written while not selected");
	a_commit: assert property (p_commit) else $error("commit not after a bit");
	a_data_grp: assert property (p_data_grp) else $error("volume outside data group");
	a_setup_grp: assert property (p_setup_grp) else $error("setup outside its group");
	a_group_hold: assert property (p_group_hold) else $error("group moved in data");
endmodule

// file: ctrl_link_dev.sv
/*
 * Codec end of the control link: samples the three lines, assembles bytes
 * and decodes them into the feature registers and their decoded values.
 * Assumes the link clock runs well below a quarter of sys_clk_in.
 */
// How it works
// - Each of the five register bytes has its own stored register
// - Address byte low bits pick the group
// - Data byte top bits pick the register
// - Low six data bits are stored
// - Setup byte: ratio, format, offset filter
// - Ratio codes give 512, 384, 256
// - Format code picks input/output justification
// - Offset filter bit enables high-pass
// - Volume byte sets both channels
// - Volume codes map to dB attenuation
// - Tone byte: bass and treble codes
// - Bass two dB per step, capped
// - Treble two dB per step, flat zero
// - Playback byte: de-emphasis, mute, mode
// - De-emphasis codes pick sample rate
// - Mute bit mutes playback
// - Mode code picks flat, min, max
// - Power byte holds two power bits
// - Upper bit ADC, lower bit DAC
// - Group 00 data, 10 setup
// - Commit only after eighth bit
// - Group holds until next address
// - Foreign address deselects the codec
`timescale 1ns/1ps
module ctrl_link_dev (
	// Clock and reset
	input  wire logic       sys_clk_in,
	input  wire logic       rstn_in,
	// Link
	ctrl_link_if.dev_end    link,
	// Setup features
	output logic [1:0]      clock_ratio_select_out,
	output logic [9:0]      clock_ratio_out,
	output logic [2:0]      input_format_out,
	output logic            fmt_in_i2s_out,
	output logic            fmt_in_msb_out,
	output logic [4:0]      fmt_in_lsb_width_out,
	output logic            fmt_out_msb_out,
	output logic            offset_filter_enable_out,
	// Volume
	output logic [5:0]      volume_code_out,
	output logic [5:0]      atten_db_out,
	output logic            atten_full_out,
	// Tone
	output logic [3:0]      bass_code_out,
	output logic [1:0]      treble_code_out,
	output logic [4:0]      bass_gain_db_out,
	output logic [2:0]      treble_gain_db_out,
	output logic            tone_mode_high_out,
	output logic            tone_mode_low_out,
	// Playback options
	output logic [1:0]      deemphasis_select_out,
	output logic            deemphasis_on_out,
	output logic            playback_mute_out,
	// Converter power
	output logic [1:0]      converter_power_select_out,
	output logic            adc_power_on_out,
	output logic            dac_power_on_out,
	// Link status
	output logic            link_selected_out,
	output logic [1:0]      link_group_out
);
	import ctrl_link_pkg::*;

	typedef struct packed {
		logic       clk_s1;     // Link clock, first stage
		logic       clk_s2;     // Link clock, second stage
		logic       clk_s3;     // Previous value for edge finding
		logic       ph_s1;      // Phase line, first stage
		logic       ph_s2;      // Phase line, second stage
		logic       ph_s3;      // Previous phase
		logic       dat_s1;     // Data line, first stage
		logic       dat_s2;     // Data line, second stage
		logic [7:0] shift;      // Byte being assembled
		logic [2:0] bit_cnt;    // Bits taken in this byte
		logic       selected;   // Our address seen last
		logic [1:0] group;      // Group from last address
		logic [5:0] setup;      // system_setup register
		logic [5:0] volume;     // volume_level register
		logic [5:0] tone;       // tone_gain register
		logic [5:0] play;       // playback_options register
		logic [5:0] power;      // converter_power register
		logic [9:0] ratio;      // Decoded clock ratio
		logic       in_i2s;     // Decoded input format
		logic       in_msb;
		logic [4:0] in_width;
		logic       out_msb;
		logic [5:0] atten;      // Decoded attenuation
		logic       full;
		logic [4:0] bass_db;    // Decoded tone gains
		logic [2:0] treb_db;
		logic       de_on;      // Any de-emphasis chosen
	} dev_state_t;

	dev_state_t r;    // Registered state
	dev_state_t n;    // Next state

	// Sampling, byte assembly, commit and decode
	always_comb begin
		logic       rise;
		logic [7:0] byte_v;
		logic [5:0] val;
		logic [1:0] mode;
		logic [4:0] bass_raw;
		rise = r.clk_s2 & ~r.clk_s3;
		byte_v = {r.dat_s2, r.shift[7:1]};
		val = byte_v[VAL_MSB:0];
		mode = 2'h0;
		bass_raw = 5'h00;
		n = r;
		// Two flops before any logic sees a pin
		n.clk_s1 = link.ctrl_clock_line;
		n.clk_s2 = r.clk_s1;
		n.clk_s3 = r.clk_s2;
		n.ph_s1 = link.ctrl_phase_line;
		n.ph_s2 = r.ph_s1;
		n.ph_s3 = r.ph_s2;
		n.dat_s1 = link.ctrl_data_line;
		n.dat_s2 = r.dat_s1;
		// A phase change restarts byte alignment
		if (r.ph_s2 != r.ph_s3) begin
			n.bit_cnt = 3'h0;
		end else if (rise) begin
			// Bits arrive least significant first
			n.shift = byte_v;
			n.bit_cnt = r.bit_cnt + 3'h1;
			if (r.bit_cnt == 3'h7) begin
				if (!r.ph_s2) begin
					// Address byte: match and remember group
					n.selected = (byte_v[ADDR_MSB:ADDR_LSB] == DEV_ADDR);
					n.group = byte_v[GRP_MSB:GRP_LSB];
				end else if (r.selected && r.group == GRP_STATUS) begin
					// Only one setup register in this group
					if (byte_v[SEL_MSB:SEL_LSB] == SEL_SETUP) begin
						n.setup = val;
					end
				end else if (r.selected && r.group == GRP_DATA) begin
					case (byte_v[SEL_MSB:SEL_LSB])
						SEL_VOLUME: n.volume = val;
						SEL_TONE:   n.tone = val;
						SEL_PLAY:   n.play = val;
						SEL_POWER:  n.power = val;
						default:    n.power = r.power;
					endcase
				end
				// Other groups and deselected state drop the byte
			end
		end

		// Clock ratio decode
		case (n.setup[CR_MSB:CR_LSB])
			2'h0:    n.ratio = RATIO_512;
			2'h1:    n.ratio = RATIO_384;
			2'h2:    n.ratio = RATIO_256;
			default: n.ratio = RATIO_NONE;
		endcase

		// Format decode; codes 5..7 pair a justified input with MSB output
		n.in_i2s = (n.setup[FMT_MSB:FMT_LSB] == 3'h0);
		n.in_msb = (n.setup[FMT_MSB:FMT_LSB] == 3'h4);
		n.out_msb = n.setup[FMT_MSB];
		case (n.setup[FMT_LSB+1:FMT_LSB])
			2'h1:    n.in_width = WID_16;
			2'h2:    n.in_width = WID_18;
			2'h3:    n.in_width = WID_20;
			default: n.in_width = 5'h00;
		endcase

		// Volume: codes 0 and 1 are 0 dB, top two codes fully attenuate
		n.full = (n.volume >= VOL_FULL_CODE);
		if (n.full) begin
			n.atten = ATTEN_FULL;
		end else if (n.volume < 6'h02) begin
			n.atten = 6'h00;
		end else begin
			n.atten = n.volume - 6'h01;
		end

		// De-emphasis flag kept in a flop so the output is registered
		n.de_on = |n.play[DE_MSB:DE_LSB];

		// Tone gains depend on mode; flat passes nothing
		mode = n.play[MODE_HI:MODE_LO];
		bass_raw = {n.tone[BASS_MSB:BASS_LSB], 1'b0};
		if (mode == MODE_FLAT) begin
			n.bass_db = 5'h00;
			n.treb_db = 3'h0;
		end else begin
			n.treb_db = {n.tone[TREB_MSB:TREB_LSB], 1'b0};
			if (mode == MODE_MAX) begin
				n.bass_db = (bass_raw > BASS_CAP_MAX) ? BASS_CAP_MAX : bass_raw;
			end else begin
				n.bass_db = (bass_raw > BASS_CAP_MIN) ? BASS_CAP_MIN : bass_raw;
			end
		end
	end

	// State register; no documented reset, so stored fields start at zero, clock and phase sync stages high
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			r <= '{clk_s1: 1'b1, clk_s2: 1'b1, clk_s3: 1'b1,
				ph_s1: 1'b1, ph_s2: 1'b1, ph_s3: 1'b1,
				setup: FIELD_RST, volume: FIELD_RST, tone: FIELD_RST,
				play: FIELD_RST, power: FIELD_RST, ratio: RATIO_512,
				in_i2s: 1'b1, default: '0};
		end else begin
			r <= n;
		end
	end

	// Setup outputs
	assign clock_ratio_select_out   = r.setup[CR_MSB:CR_LSB];
	assign clock_ratio_out          = r.ratio;
	assign input_format_out         = r.setup[FMT_MSB:FMT_LSB];
	assign fmt_in_i2s_out           = r.in_i2s;
	assign fmt_in_msb_out           = r.in_msb;
	assign fmt_in_lsb_width_out     = r.in_width;
	assign fmt_out_msb_out          = r.out_msb;
	assign offset_filter_enable_out = r.setup[OFS_BIT];
	// Volume outputs, same for both channels
	assign volume_code_out          = r.volume;
	assign atten_db_out             = r.atten;
	assign atten_full_out           = r.full;
	// Tone outputs
	assign bass_code_out            = r.tone[BASS_MSB:BASS_LSB];
	assign treble_code_out          = r.tone[TREB_MSB:TREB_LSB];
	assign bass_gain_db_out         = r.bass_db;
	assign treble_gain_db_out       = r.treb_db;
	assign tone_mode_high_out       = r.play[MODE_HI];
	assign tone_mode_low_out        = r.play[MODE_LO];
	// Playback outputs
	assign deemphasis_select_out    = r.play[DE_MSB:DE_LSB];
	assign deemphasis_on_out        = r.de_on;
	assign playback_mute_out        = r.play[MUTE_BIT];
	// Power outputs
	assign converter_power_select_out = r.power[PWR_ADC:PWR_DAC];
	assign adc_power_on_out         = r.power[PWR_ADC];
	assign dac_power_on_out         = r.power[PWR_DAC];
	// Link status
	assign link_selected_out        = r.selected;
	assign link_group_out           = r.group;
endmodule

// file: ctrl_link_host.sv
/*
 * Host end of the control link: serialises address and data bytes written
 * to its command registers, making the link clock by dividing sys_clk_in.
 * Assumes a plain register port with one-cycle strobes.
 */
`timescale 1ns/1ps
module ctrl_link_host #(
	parameter int HALF_CYC = ctrl_link_pkg::LINK_HALF_CYC
) (
	// Clock and reset
	input  wire logic                 sys_clk_in,
	input  wire logic                 rstn_in,
	// Register port
	input  wire logic [3:0]           reg_addr_in,
	input  wire logic [7:0]           reg_wdata_in,
	input  wire logic                 reg_wr_in,
	input  wire logic                 reg_rd_in,
	output logic      [7:0]           reg_rdata_out,
	// Link
	ctrl_link_if.host_end             link
);
	import ctrl_link_pkg::*;

	// Divider must hold at least two cycles per half period
	if (HALF_CYC < 2 || HALF_CYC > 255) begin : g_bad_half
		$error("HALF_CYC out of range");
	end

	typedef enum logic [2:0] {IDLE, SETUP, LOW, HIGH, HOLD} host_st_t;

	typedef struct packed {
		host_st_t   st;         // Sequencer state
		logic [7:0] shreg;      // Byte being sent
		logic [2:0] bitn;       // Bits sent so far
		logic [7:0] cnt;        // Half period timer
		logic       clk;        // Link clock
		logic       dat;        // Link data
		logic       phase;      // Link phase
		logic       drop;       // Write refused while busy
		logic [7:0] last_addr;  // Last address byte taken
		logic [7:0] last_data;  // Last data byte taken
		logic [7:0] rdata;      // Read answer
	} host_state_t;

	host_state_t r;    // Registered state
	host_state_t n;    // Next state

	// Sequencer and register port
	always_comb begin
		logic tick;
		logic busy;
		tick = (r.cnt == 8'h00);
		busy = (r.st != IDLE);
		n = r;
		n.rdata = 8'h00;
		if (!tick) begin
			n.cnt = r.cnt - 8'h01;
		end
		case (r.st)
			IDLE: begin
				n.clk = 1'b1;
			end
			SETUP: begin
				if (tick) begin
					n.st = LOW;
					n.clk = 1'b0;
					n.dat = r.shreg[0];
					n.cnt = 8'(HALF_CYC - 1);
				end
			end
			LOW: begin
				if (tick) begin
					n.st = HIGH;
					n.clk = 1'b1;
					n.cnt = 8'(HALF_CYC - 1);
				end
			end
			HIGH: begin
				if (tick) begin
					n.shreg = {1'b0, r.shreg[7:1]};
					n.bitn = r.bitn + 3'h1;
					n.cnt = 8'(HALF_CYC - 1);
					if (r.bitn == 3'h7) begin
						n.st = HOLD;
					end else begin
						n.st = LOW;
						n.clk = 1'b0;
						n.dat = r.shreg[1];
					end
				end
			end
			HOLD: begin
				// Back to data phase so a later data byte needs no extra edge
				if (tick) begin
					n.st = IDLE;
					n.phase = 1'b1;
				end
			end
			default: begin
				n.st = IDLE;
			end
		endcase
		// Writes start a byte; a busy sequencer refuses them
		if (reg_wr_in && (reg_addr_in == HREG_ADDR || reg_addr_in == HREG_DATA)) begin
			if (busy) begin
				n.drop = 1'b1;
			end else begin
				n.st = SETUP;
				n.shreg = reg_wdata_in;
				n.bitn = 3'h0;
				n.cnt = 8'(HALF_CYC - 1);
				n.phase = (reg_addr_in == HREG_DATA);
				if (reg_addr_in == HREG_ADDR) begin
					n.last_addr = reg_wdata_in;
				end else begin
					n.last_data = reg_wdata_in;
				end
			end
		end
		// Reads answer one cycle later; status read clears drop unless set
		if (reg_rd_in) begin
			case (reg_addr_in)
				HREG_ADDR: n.rdata = r.last_addr;
				HREG_DATA: n.rdata = r.last_data;
				HREG_STATUS: begin
					n.rdata[ST_BUSY] = busy;
					n.rdata[ST_DROP] = r.drop;
					if (!(reg_wr_in && busy)) begin
						n.drop = 1'b0;
					end
				end
				default: n.rdata = 8'h00;
			endcase
		end
	end

	// State register
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			r <= '{st: IDLE, clk: 1'b1, phase: 1'b1, default: '0};
		end else begin
			r <= n;
		end
	end

	assign reg_rdata_out        = r.rdata;
	assign link.ctrl_clock_line = r.clk;
	assign link.ctrl_data_line  = r.dat;
	assign link.ctrl_phase_line = r.phase;
endmodule

// file: ctrl_link_if.sv
/*
 * Three-wire serial control link between host and codec.
 * Assumes the host drives all three lines and the codec only listens.
 */
`timescale 1ns/1ps
interface ctrl_link_if;
	logic ctrl_phase_line;  // Low: address phase, high: data phase
	logic ctrl_clock_line;  // Bit clock, idles high, data taken on rise
	logic ctrl_data_line;   // Serial data, least significant bit first

	// Host end drives the link
	modport host_end (
		output ctrl_phase_line,
		output ctrl_clock_line,
		output ctrl_data_line
	);

	// Codec end only samples it
	modport dev_end (
		input ctrl_phase_line,
		input ctrl_clock_line,
		input ctrl_data_line
	);
endinterface

// file: ctrl_link_pkg.sv
/*
 * Shared constants for the serial control link: device address, transfer
 * groups, byte field positions, decode values and host register offsets.
 * Assumes both link ends and the bench import this one package.
 */
package ctrl_link_pkg;

	// Timing of the host-made link clock
	localparam int SYS_CLK_NS    = 4;   // System clock period
	localparam int LINK_HALF_NS  = 24;  // Least half period of link clock
	localparam int LINK_HALF_CYC = (LINK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

	// Device identity; the value is arbitrary
	localparam logic [5:0] DEV_ADDR = 6'h2A;

	// Address byte layout
	localparam int ADDR_MSB = 7;
	localparam int ADDR_LSB = 2;
	localparam int GRP_MSB  = 1;
	localparam int GRP_LSB  = 0;

	// Transfer group codes
	localparam logic [1:0] GRP_DATA   = 2'h0;
	localparam logic [1:0] GRP_STATUS = 2'h2;

	// Data byte layout: select bits and value bits
	localparam int SEL_MSB = 7;
	localparam int SEL_LSB = 6;
	localparam int VAL_MSB = 5;

	// Register select codes
	localparam logic [1:0] SEL_SETUP  = 2'h0;
	localparam logic [1:0] SEL_VOLUME = 2'h0;
	localparam logic [1:0] SEL_TONE   = 2'h1;
	localparam logic [1:0] SEL_PLAY   = 2'h2;
	localparam logic [1:0] SEL_POWER  = 2'h3;

	// Field positions inside the six value bits
	localparam int CR_MSB    = 5;
	localparam int CR_LSB    = 4;
	localparam int FMT_MSB   = 3;
	localparam int FMT_LSB   = 1;
	localparam int OFS_BIT   = 0;
	localparam int BASS_MSB  = 5;
	localparam int BASS_LSB  = 2;
	localparam int TREB_MSB  = 1;
	localparam int TREB_LSB  = 0;
	localparam int DE_MSB    = 4;
	localparam int DE_LSB    = 3;
	localparam int MUTE_BIT  = 2;
	localparam int MODE_HI   = 1;
	localparam int MODE_LO   = 0;
	localparam int PWR_ADC   = 1;
	localparam int PWR_DAC   = 0;

	// Reset value of every stored field
	localparam logic [5:0] FIELD_RST = 6'h00;

	// Clock ratio decode, in multiples of the sample rate
	localparam logic [9:0] RATIO_512 = 10'h200;
	localparam logic [9:0] RATIO_384 = 10'h180;
	localparam logic [9:0] RATIO_256 = 10'h100;
	localparam logic [9:0] RATIO_NONE = 10'h000;

	// Input word widths for justified formats
	localparam logic [4:0] WID_16 = 5'h10;
	localparam logic [4:0] WID_18 = 5'h12;
	localparam logic [4:0] WID_20 = 5'h14;

	// Volume: codes from here up attenuate fully
	localparam logic [5:0] VOL_FULL_CODE = 6'h3E;
	localparam logic [5:0] ATTEN_FULL    = 6'h3F;

	// Tone modes and bass caps in dB
	localparam logic [1:0] MODE_FLAT    = 2'h0;
	localparam logic [1:0] MODE_MAX     = 2'h3;
	localparam logic [4:0] BASS_CAP_MIN = 5'h12;
	localparam logic [4:0] BASS_CAP_MAX = 5'h18;

	// Host command register offsets
	localparam logic [3:0] HREG_ADDR   = 4'h0;
	localparam logic [3:0] HREG_DATA   = 4'h1;
	localparam logic [3:0] HREG_STATUS = 4'h2;
	localparam int ST_BUSY = 0;
	localparam int ST_DROP = 1;

endpackage

// file: tb_top.sv
/*
 * Bench for host and codec ends joined by the control link.
 * Assumes host offsets and status bits as set in the shared package.
 */
`timescale 1ns/1ps
module tb_top;
	import ctrl_link_pkg::*;
	// Clock, reset and host register port
	logic       sys_clk_in, rstn_in, reg_wr_in, reg_rd_in;
	logic [3:0] reg_addr_in;
	logic [7:0] reg_wdata_in, reg_rdata_out, s;
	// Codec outputs
	logic [9:0] clock_ratio_out;
	logic [5:0] volume_code_out, atten_db_out;
	logic [4:0] fmt_in_lsb_width_out, bass_gain_db_out;
	logic [3:0] bass_code_out;
	logic [2:0] input_format_out, treble_gain_db_out;
	logic [1:0] clock_ratio_select_out, treble_code_out, deemphasis_select_out;
	logic [1:0] converter_power_select_out, link_group_out;
	logic       fmt_in_i2s_out, fmt_in_msb_out, fmt_out_msb_out, offset_filter_enable_out;
	logic       atten_full_out, tone_mode_high_out, tone_mode_low_out, deemphasis_on_out;
	logic       playback_mute_out, adc_power_on_out, dac_power_on_out, link_selected_out;
	// Expected register image
	logic [5:0] s_set, s_vol, s_tone, s_play, s_pwr;
	logic       s_sel;
	logic [1:0] s_grp;
	int         mismatches, n_checks, cyc;
	// Ordinary cases: address byte, data byte
	logic [15:0] rows [31] = '{16'hAA00, 16'hAA13, 16'hAA25, 16'hAA36, 16'hAA09, 16'hAA1A,
		16'hAA2D, 16'hAA3E, 16'hAA7F, 16'hA800, 16'hA801, 16'hA802, 16'hA83D, 16'hA83E,
		16'hA83F, 16'hA87F, 16'hA883, 16'hA881, 16'hA882, 16'hA880, 16'hA846, 16'hA888,
		16'hA894, 16'hA89B, 16'hA8C0, 16'hA8C1, 16'hA8C2, 16'hA8C3, 16'hA9C0, 16'hABC0,
		16'h54C0};
	logic [9:0] ratio_tab [4] = '{10'h200, 10'h180, 10'h100, 10'h000};

	ctrl_link_if link();
	ctrl_link_host i_ctrl_link_host (.*);
	ctrl_link_dev i_ctrl_link_dev (.*);
	ctrl_link_assertions i_ctrl_link_assertions (.ctrl_phase_line(link.ctrl_phase_line),
		.ctrl_clock_line(link.ctrl_clock_line), .*);

	// Free-running system clock
	initial begin
		sys_clk_in = 1'b0;
		forever #2 sys_clk_in = ~sys_clk_in;
	end

	// Hang guard, well above the expected run
	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			give_verdict();
		end
	end

	task give_verdict;
		if (mismatches == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task chk(input logic [9:0] seen, input logic [9:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One register write; gap cycle keeps strobe edges apart
	task wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
		@(posedge sys_clk_in);
	endtask

	// One register read; data stand only in the following cycle
	task rd(input logic [3:0] a, output logic [7:0] d);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		#1 d = reg_rdata_out;
		@(posedge sys_clk_in);
	endtask

	// Poll busy, bounded; margin lets the codec commit
	task wait_idle;
		logic [7:0] st;
		st = 8'h01;
		for (int i = 0; i < 100 && st[ST_BUSY]; i++) rd(HREG_STATUS, st);
		if (st[ST_BUSY]) chk(10'h001, 10'h000);
		repeat (6) @(posedge sys_clk_in);
	endtask

	task clear_model;
		{s_set, s_vol, s_tone, s_play, s_pwr, s_sel, s_grp} = '0;
	endtask

	// Expected effect of one byte on the codec
	function void model(input logic is_addr, input logic [7:0] b);
		if (is_addr) begin
			s_sel = (b[7:2] == DEV_ADDR);
			s_grp = b[1:0];
		end else if (s_sel && s_grp == 2'h2 && b[7:6] == 2'h0) begin
			s_set = b[5:0];
		end else if (s_sel && s_grp == 2'h0) begin
			case (b[7:6])
				2'h0: s_vol = b[5:0];
				2'h1: s_tone = b[5:0];
				2'h2: s_play = b[5:0];
				default: s_pwr = b[5:0];
			endcase
		end
	endfunction

	// Every output against the image (group only while selected), so untouched features are seen too
	task check_all;
		logic [4:0] b2, cap;
		logic [1:0] m;
		m = s_play[1:0];
		b2 = {s_tone[5:2], 1'b0};
		cap = (m == 2'h3) ? 5'h18 : 5'h12;
		chk(clock_ratio_select_out, s_set[5:4]);
		chk(clock_ratio_out, ratio_tab[s_set[5:4]]);
		chk(input_format_out, s_set[3:1]);
		chk(fmt_in_i2s_out, s_set[3:1] == 3'h0);
		chk(fmt_in_msb_out, s_set[3:1] == 3'h4);
		chk(fmt_in_lsb_width_out, s_set[2:1] == 0 ? 5'h00 : 5'h0E + {s_set[2:1], 1'b0});
		chk(fmt_out_msb_out, s_set[3]);
		chk(offset_filter_enable_out, s_set[0]);
		chk(volume_code_out, s_vol);
		chk(atten_db_out, s_vol < 2 ? 6'h00 : s_vol > 61 ? 6'h3F : s_vol - 6'h01);
		chk(atten_full_out, s_vol > 61);
		chk(bass_code_out, s_tone[5:2]);
		chk(treble_code_out, s_tone[1:0]);
		chk(bass_gain_db_out, m == 0 ? 5'h00 : (b2 > cap ? cap : b2));
		chk(treble_gain_db_out, m == 0 ? 3'h0 : {s_tone[1:0], 1'b0});
		chk(tone_mode_high_out, m[1]);
		chk(tone_mode_low_out, m[0]);
		chk(deemphasis_select_out, s_play[4:3]);
		chk(deemphasis_on_out, s_play[4:3] != 0);
		chk(playback_mute_out, s_play[2]);
		chk(converter_power_select_out, s_pwr[1:0]);
		chk(adc_power_on_out, s_pwr[1]);
		chk(dac_power_on_out, s_pwr[0]);
		chk(link_selected_out, s_sel);
		if (s_sel) chk(link_group_out, s_grp);
	endtask

	task send(input logic [3:0] a, input logic [7:0] d);
		wr(a, d);
		wait_idle();
		model(a == HREG_ADDR, d);
		check_all();
	endtask

	// Main sequence
	initial begin
		{rstn_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
		clear_model();
		repeat (12) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		@(posedge sys_clk_in);
		check_all();
		foreach (rows[i]) begin
			send(HREG_ADDR, rows[i][15:8]);
			send(HREG_DATA, rows[i][7:0]);
		end
		// Several data bytes under one address
		send(HREG_ADDR, 8'hA8);
		send(HREG_DATA, 8'h05);
		send(HREG_DATA, 8'h47);
		send(HREG_DATA, 8'hC2);
		send(HREG_DATA, 8'h69);
		// Second write while busy is refused
		reg_addr_in <= HREG_DATA;
		reg_wdata_in <= 8'h3F;
		reg_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_wdata_in <= 8'h11;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
		@(posedge sys_clk_in);
		rd(HREG_STATUS, s);
		chk(s[1:0], 2'h3);
		wait_idle();
		model(1'b0, 8'h3F);
		check_all();
		rd(HREG_DATA, s);
		chk(s, 8'h3F);
		rd(4'hF, s);
		chk(s, 8'h00);
		rd(HREG_ADDR, s);
		chk(s, 8'hA8);
		rd(HREG_STATUS, s);
		chk(s, 8'h00);
		// Reset in mid-run clears every stored field
		rstn_in <= 1'b0;
		repeat (3) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		@(posedge sys_clk_in);
		clear_model();
		check_all();
		give_verdict();
	end
endmodule
